// ==== src/lorp_core.sv ====
// execute stage for or, or-with-complement and halfword pack
// assumes decode hands one instruction per cycle with register values already read;
// the immediate expander is outside and gives the constant and its carry
`timescale 1ns/1ps
`include "lorp_consts.svh"
module lorp_core
    import lorp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic issue_valid,
    input wire logic [31:0] instr_word,
    input wire logic instr_wide,
    input wire logic condition_check_pass,
    input wire logic in_conditional_block,
    input wire logic main_extension_present,
    input wire logic signal_ext_present,
    input wire logic [31:0] first_src_value,
    input wire logic [31:0] second_src_value,
    input wire logic [31:0] expanded_imm,
    input wire logic expanded_carry,
    input wire logic [3:0] condition_flags_word,
    output logic [11:0] imm_field_out,
    output logic wr_en_ff,
    output logic [3:0] wr_addr_ff,
    output logic [31:0] wr_data_ff,
    output logic flags_en_ff,
    output logic [3:0] flags_ff,
    output logic undefined_ff,
    output logic unpredictable_ff,
    output logic redirect_ff,
    output lorp_op_t op_ff
);
    // flags word layout n z c v in bits 3..0
    function automatic logic is_sp_pc(input logic [3:0] r);
        is_sp_pc = (r == `LORP_REG_SP) || (r == `LORP_REG_PC);
    endfunction

    // fixed-bit pattern match shared by every wide encoding check
    function automatic logic is_match(input logic [31:0] w, input logic [31:0] mask, input logic [31:0] pat);
        is_match = (w & mask) == pat;
    endfunction

    logic [15:0] hw_hi;
    logic [15:0] hw_lo;
    logic [3:0] first_src_field;
    logic [3:0] second_src_field;
    logic [3:0] dest_field;
    logic [2:0] amount_high_field;
    logic [1:0] amount_low_field;
    logic [1:0] shift_kind_field;
    logic [7:0] byte_immediate_field;
    logic half_select_bit;
    logic s_bit;
    logic t_bit;
    logic hit_or_imm;
    logic hit_orc_imm;
    logic hit_or_reg;
    logic hit_orc_reg;
    logic hit_pkh;
    logic hit_narrow;
    logic [4:0] amount;
    logic [1:0] sh_kind;
    logic [5:0] sh_count;
    logic sh_thru;
    logic [31:0] sh_result;
    logic sh_carry;
    logic [31:0] result;
    logic res_carry;
    logic set_flags;
    logic undef;
    logic unpred;
    logic redirect;
    lorp_op_t op;
    logic [3:0] dest;

    assign hw_hi = instr_word[31:16];
    assign hw_lo = instr_word[15:0];
    assign first_src_field = hw_hi[3:0];
    assign second_src_field = hw_lo[3:0];
    assign dest_field = hw_lo[11:8];
    assign amount_high_field = hw_lo[14:12];
    assign amount_low_field = hw_lo[7:6];
    assign shift_kind_field = hw_lo[5:4];
    assign byte_immediate_field = hw_lo[7:0];
    assign half_select_bit = hw_lo[5];
    assign t_bit = hw_lo[4];
    assign s_bit = hw_hi[4];
    assign amount = {amount_high_field, amount_low_field};
    assign imm_field_out = {hw_hi[10], amount_high_field, byte_immediate_field};

    assign hit_or_imm = instr_wide && is_match(instr_word, `LORP_W_IMM_MASK, `LORP_W_OR_IMM);
    assign hit_orc_imm = instr_wide && is_match(instr_word, `LORP_W_IMM_MASK, `LORP_W_ORC_IMM);
    assign hit_or_reg = instr_wide && is_match(instr_word, `LORP_W_REG_MASK, `LORP_W_OR_REG);
    assign hit_orc_reg = instr_wide && is_match(instr_word, `LORP_W_REG_MASK, `LORP_W_ORC_REG);
    assign hit_pkh = instr_wide && is_match(instr_word, `LORP_W_PKH_MASK, `LORP_W_PKH);
    assign hit_narrow = !instr_wide && ((hw_lo & `LORP_N_OR_MASK) == `LORP_N_OR);

    // decode of shift kind and count
    always_comb begin
        sh_kind = shift_kind_field;
        sh_count = {1'b0, amount};
        sh_thru = 1'b0;
        if (hit_narrow) begin
            sh_kind = `LORP_SH_LSL;
            sh_count = 6'h0;
        end else if (hit_pkh) begin
            sh_kind = half_select_bit ? `LORP_SH_ASR : `LORP_SH_LSL;
            if (half_select_bit && amount == 5'h0) begin
                sh_count = `LORP_SH_MAX;
            end
        end else if (amount == 5'h0) begin
            // zero means 32 for right shifts
            if (shift_kind_field == `LORP_SH_LSR || shift_kind_field == `LORP_SH_ASR) begin
                sh_count = `LORP_SH_MAX;
            end
            // ror by zero rotates through carry
            sh_thru = (shift_kind_field == `LORP_SH_ROR);
        end
    end

    lorp_shifter u_shifter (
        .value(second_src_value),
        .kind(sh_kind),
        .count(sh_count),
        .thru_carry(sh_thru),
        .carry_in(condition_flags_word[1]),
        .result(sh_result),
        .carry_out(sh_carry)
    );

    // operation select, result and checks
    always_comb begin
        op = LORP_OP_NONE;
        result = 32'h0;
        res_carry = condition_flags_word[1];
        set_flags = 1'b0;
        undef = 1'b0;
        unpred = 1'b0;
        redirect = 1'b0;
        dest = dest_field;
        if (hit_or_imm || hit_orc_imm) begin
            if (first_src_field == `LORP_REG_NONE) begin
                // or immediate first 1111 is move
                op = hit_or_imm ? LORP_OP_MOVE : LORP_OP_NOT;
                redirect = 1'b1;
            end else if (!main_extension_present) begin
                undef = 1'b1;
            end else begin
                op = hit_or_imm ? LORP_OP_OR : LORP_OP_ORC;
                result = hit_or_imm ? (first_src_value | expanded_imm) : (first_src_value | ~expanded_imm);
                res_carry = expanded_carry;
                set_flags = s_bit;
                unpred = is_sp_pc(dest_field) || (first_src_field == `LORP_REG_SP);
            end
        end else if (hit_or_reg || hit_orc_reg) begin
            if (first_src_field == `LORP_REG_NONE) begin
                // or register first 1111 is move
                // or-complement register first 1111 is not
                op = hit_or_reg ? LORP_OP_MOVE : LORP_OP_NOT;
                redirect = 1'b1;
            end else if (!main_extension_present) begin
                undef = 1'b1;
            end else begin
                op = hit_or_reg ? LORP_OP_OR : LORP_OP_ORC;
                result = hit_or_reg ? (first_src_value | sh_result) : (first_src_value | ~sh_result);
                res_carry = sh_carry;
                set_flags = s_bit;
                unpred = is_sp_pc(dest_field) || (first_src_field == `LORP_REG_SP) ||
                         is_sp_pc(second_src_field);
            end
        end else if (hit_pkh) begin
            // s, t or missing dsp undefined
            if (s_bit || t_bit || !signal_ext_present) begin
                undef = 1'b1;
            end else begin
                op = LORP_OP_PACK;
                // low half from shifted in top variant
                result[15:0] = half_select_bit ? sh_result[15:0] : first_src_value[15:0];
                result[31:16] = half_select_bit ? first_src_value[31:16] : sh_result[31:16];
                unpred = is_sp_pc(dest_field) || is_sp_pc(first_src_field) || is_sp_pc(second_src_field);
            end
        end else if (hit_narrow) begin
            op = LORP_OP_OR;
            // shared register is source and destination
            dest = {1'b0, hw_lo[2:0]};
            result = first_src_value | second_src_value;
            res_carry = sh_carry;
            set_flags = !in_conditional_block;
        end
    end

    // unpredictable encodings are flagged and not committed; a conservative choice
    logic commit;
    assign commit = issue_valid && condition_check_pass && !undef && !unpred && !redirect &&
                    (op != LORP_OP_NONE);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_en_ff <= 1'b0;
        end else begin
            wr_en_ff <= commit;
        end
    end

    // address and data follow every cycle; only the enable says they count
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_addr_ff <= 4'h0;
        end else begin
            wr_addr_ff <= dest;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_data_ff <= 32'h0;
        end else begin
            wr_data_ff <= result;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags_en_ff <= 1'b0;
        end else begin
            flags_en_ff <= commit && set_flags;
        end
    end

    // overflow passes through so the flags word can be written whole
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags_ff <= 4'h0;
        end else begin
            flags_ff <= {result[31], result == 32'h0, res_carry, condition_flags_word[0]};
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            undefined_ff <= 1'b0;
        end else begin
            undefined_ff <= issue_valid && undef;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            unpredictable_ff <= 1'b0;
        end else begin
            unpredictable_ff <= issue_valid && unpred;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            redirect_ff <= 1'b0;
        end else begin
            redirect_ff <= issue_valid && redirect;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            op_ff <= LORP_OP_NONE;
        end else begin
            op_ff <= issue_valid ? op : LORP_OP_NONE;
        end
    end
endmodule

// ==== src/lorp_consts.svh ====
// constants for the logical or / pack execute datapath
// assumes a 32-bit two-halfword instruction word, first halfword in [31:16]
`ifndef LORP_CONSTS_SVH
`define LORP_CONSTS_SVH
`define LORP_REG_SP 4'hd
`define LORP_REG_PC 4'hf
`define LORP_REG_NONE 4'hf
`define LORP_SH_LSL 2'h0
`define LORP_SH_LSR 2'h1
`define LORP_SH_ASR 2'h2
`define LORP_SH_ROR 2'h3
// right shifts encode a distance of 32 as zero
`define LORP_SH_MAX 6'h20
// wide and narrow encoding major pattern checks
`define LORP_W_IMM_MASK 32'hfbe08000
`define LORP_W_OR_IMM 32'hf0400000
`define LORP_W_ORC_IMM 32'hf0600000
`define LORP_W_REG_MASK 32'hffe08000
`define LORP_W_OR_REG 32'hea400000
`define LORP_W_ORC_REG 32'hea600000
`define LORP_W_PKH_MASK 32'hffe08000
`define LORP_W_PKH 32'heac00000
`define LORP_N_OR_MASK 16'hffc0
`define LORP_N_OR 16'h4300
`endif

// ==== src/lorp_pkg.sv ====
// types for the logical or / pack execute datapath
// assumes lorp_consts.svh is included by users needing numbers
package lorp_pkg;
    typedef enum logic [5:0] {
        LORP_OP_NONE = 6'h01,
        LORP_OP_OR = 6'h02,
        LORP_OP_ORC = 6'h04,
        LORP_OP_PACK = 6'h08,
        LORP_OP_MOVE = 6'h10,
        LORP_OP_NOT = 6'h20
    } lorp_op_t;
endpackage

// ==== src/lorp_shifter.sv ====
// immediate-count barrel shifter with carry out
// assumes a count already decoded: 0 means no shift, carry rotate flagged separately
`timescale 1ns/1ps
`include "lorp_consts.svh"
module lorp_shifter (
    input wire logic [31:0] value,
    input wire logic [1:0] kind,
    input wire logic [5:0] count,
    input wire logic thru_carry,
    input wire logic carry_in,
    output logic [31:0] result,
    output logic carry_out
);
    logic [63:0] wide;
    always_comb begin
        wide = 64'h0;
        result = value;
        carry_out = carry_in;
        if (thru_carry) begin
            result = {carry_in, value[31:1]};
            carry_out = value[0];
        end else if (count != 6'h0) begin
            case (kind)
                `LORP_SH_LSL: begin
                    wide = {32'h0, value} << count;
                    result = wide[31:0];
                    carry_out = wide[32];
                end
                `LORP_SH_LSR: begin
                    wide = {value, 32'h0} >> count;
                    result = wide[63:32];
                    carry_out = wide[31];
                end
                `LORP_SH_ASR: begin
                    wide = $signed({value, 32'h0}) >>> count;
                    result = wide[63:32];
                    carry_out = wide[31];
                end
                default: begin
                    wide = {value, value} >> count[4:0];
                    result = wide[31:0];
                    carry_out = wide[31];
                end
            endcase
        end
    end
endmodule

// ==== verification/lorp_core_assertions.sv ====
// assertion checker for the or / pack execute stage
// assumes it is bound to lorp_core and sees only its ports
`timescale 1ns/1ps
`include "lorp_consts.svh"
module lorp_checker
    import lorp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic issue_valid,
    input wire logic [31:0] instr_word,
    input wire logic instr_wide,
    input wire logic condition_check_pass,
    input wire logic in_conditional_block,
    input wire logic main_extension_present,
    input wire logic [31:0] first_src_value,
    input wire logic [31:0] expanded_imm,
    input wire logic expanded_carry,
    input wire logic [3:0] condition_flags_word,
    input wire logic wr_en_ff,
    input wire logic [3:0] wr_addr_ff,
    input wire logic [31:0] wr_data_ff,
    input wire logic flags_en_ff,
    input wire logic [3:0] flags_ff,
    input wire logic undefined_ff,
    input wire logic unpredictable_ff,
    input wire logic redirect_ff,
    input wire lorp_op_t op_ff
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff rst;
    logic go;
    logic regs_ok;
    logic take;
    // operands kept below 13 so no reject path muddies the data checks
    assign regs_ok = instr_word[19:16] < 4'hd && instr_word[11:8] < 4'hd && instr_word[3:0] < 4'hd;
    assign take = issue_valid && condition_check_pass && instr_wide;
    assign go = take && main_extension_present;
    a_cond_fail_idle: assert property (issue_valid && !condition_check_pass |=> !wr_en_ff && !flags_en_ff)
        else $error("write despite failed condition");
    a_orc_imm_data: assert property (go && regs_ok && (instr_word & `LORP_W_IMM_MASK) == `LORP_W_ORC_IMM
        |=> wr_en_ff && wr_data_ff == ($past(first_src_value) | ~$past(expanded_imm)))
        else $error("bad or-complement result");
    a_imm_carry_load: assert property (go && regs_ok && (instr_word & `LORP_W_IMM_MASK) == `LORP_W_OR_IMM
        && instr_word[20] |=> flags_en_ff && flags_ff[1] == $past(expanded_carry)) else $error("bad imm carry");
    a_flags_nz_v: assert property (flags_en_ff |-> flags_ff[3] == wr_data_ff[31] && flags_ff[2] == (wr_data_ff == 32'h0)
        && flags_ff[0] == $past(condition_flags_word[0])) else $error("bad n z v flags");
    a_sbit_flags: assert property (go && regs_ok && (instr_word & `LORP_W_REG_MASK) == `LORP_W_OR_REG
        |=> flags_en_ff == $past(instr_word[20])) else $error("flag enable not from s bit");
    a_no_main_undef: assert property (take && !main_extension_present && instr_word[19:16] != 4'hf
        && (instr_word & `LORP_W_REG_MASK) == `LORP_W_OR_REG |=> undefined_ff && !wr_en_ff) else $error("missing undef");
    a_redirect_move: assert property (take && instr_word[19:16] == 4'hf
        && (instr_word & `LORP_W_REG_MASK) == `LORP_W_OR_REG |=> redirect_ff && op_ff == LORP_OP_MOVE && !wr_en_ff)
        else $error("missing move redirect");
    a_unpred_dest: assert property (go && instr_word[11:8] == `LORP_REG_SP && instr_word[19:16] != 4'hf
        && (instr_word & `LORP_W_REG_MASK) == `LORP_W_OR_REG |=> unpredictable_ff && !wr_en_ff) else $error("sp dest kept");
    a_narrow_flags: assert property (issue_valid && condition_check_pass && !instr_wide
        && (instr_word[15:0] & `LORP_N_OR_MASK) == `LORP_N_OR |=> wr_en_ff
        && flags_en_ff == !$past(in_conditional_block) && wr_addr_ff == {1'b0, $past(instr_word[2:0])})
        else $error("bad narrow or");
    a_pack_undef: assert property (take && (instr_word & `LORP_W_PKH_MASK) == `LORP_W_PKH
        && (instr_word[20] || instr_word[4]) |=> undefined_ff && !wr_en_ff) else $error("pack s or t accepted");
    a_idle_quiet: assert property (!issue_valid |=> !wr_en_ff && !flags_en_ff)
        else $error("write without issue");
endmodule

bind lorp_core lorp_checker chk_u (.core_clk, .rst, .issue_valid, .instr_word, .instr_wide, .condition_check_pass,
    .in_conditional_block, .main_extension_present, .first_src_value, .expanded_imm, .expanded_carry,
    .condition_flags_word, .wr_en_ff, .wr_addr_ff, .wr_data_ff, .flags_en_ff, .flags_ff, .undefined_ff,
    .unpredictable_ff, .redirect_ff, .op_ff);

// ==== verification/lorp_core_tb.sv ====
// self-checking bench for the or / pack execute stage
// assumes the bench stands in for decode, register file and immediate expander
`timescale 1ns/1ps
`include "lorp_consts.svh"
module lorp_core_tb
    import lorp_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic issue_valid = 1'b0;
    logic instr_wide = 1'b0;
    logic condition_check_pass = 1'b1;
    logic in_conditional_block = 1'b0;
    logic main_extension_present = 1'b1;
    logic signal_ext_present = 1'b1;
    logic expanded_carry = 1'b0;
    logic [31:0] instr_word = 32'h0;
    logic [31:0] first_src_value = 32'h0;
    logic [31:0] second_src_value = 32'h0;
    logic [31:0] expanded_imm = 32'h0;
    // c and v set so carry-in and kept overflow are visible
    logic [3:0] condition_flags_word = 4'h3;
    logic [11:0] imm_field_out;
    logic [3:0] wr_addr_ff, flags_ff;
    logic [31:0] wr_data_ff;
    logic wr_en_ff, flags_en_ff, undefined_ff, unpredictable_ff, redirect_ff;
    lorp_op_t op_ff;
    int num_errors = 0;
    int compares = 0;
    lorp_core dut_u (.core_clk, .rst, .issue_valid, .instr_word, .instr_wide, .condition_check_pass,
        .in_conditional_block, .main_extension_present, .signal_ext_present, .first_src_value,
        .second_src_value, .expanded_imm, .expanded_carry, .condition_flags_word, .imm_field_out,
        .wr_en_ff, .wr_addr_ff, .wr_data_ff, .flags_en_ff, .flags_ff, .undefined_ff, .unpredictable_ff,
        .redirect_ff, .op_ff);
    always #2.5 core_clk = ~core_clk;
    task automatic print_verdict();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // env is {condition pass, main ext, dsp ext, expander carry}
    task automatic run(input logic [31:0] w, input logic wd, input logic [3:0] env, input logic [31:0] a, b, im);
        @(posedge core_clk);
        issue_valid <= 1'b1;
        instr_word <= w;
        instr_wide <= wd;
        {condition_check_pass, main_extension_present, signal_ext_present, expanded_carry} <= env;
        first_src_value <= a;
        second_src_value <= b;
        expanded_imm <= im;
        @(posedge core_clk);
        issue_valid <= 1'b0;
        #1;
    endtask
    task automatic expect_wr(input logic [31:0] d, input logic fe, input logic [3:0] fl);
        check(wr_en_ff, 1'b1);
        check(wr_data_ff, d);
        check(flags_en_ff, fe);
        if (fe) check(flags_ff, fl);
    endtask
    // returns {carry, result}; written from the shift table, not shared with the design
    function automatic logic [32:0] ref_sh(input logic [31:0] v, input logic [1:0] t, input logic [4:0] am,
        input logic ci);
        logic [32:0] y;
        logic [63:0] d;
        int n;
        n = (am == 5'h0) ? 32 : am;
        d = {v, v} >> n;
        case (t)
            2'h0: y = (am == 5'h0) ? {ci, v} : {1'b0, v} << n;
            2'h1: y = {v, 1'b0} >> n;
            2'h2: y = $signed({v, 1'b0}) >>> n;
            default: y = (am == 5'h0) ? {ci, v} : {d[31:0], d[31]};
        endcase
        return (t == 2'h0) ? y : {y[0], y[32:1]};
    endfunction
    task automatic s_imm();
        run(32'hf0710200, 1'b1, 4'hf, 32'h8000_0000, 32'h0, 32'hffff_ffff);
        expect_wr(32'h8000_0000, 1'b1, 4'hb);
        check(wr_addr_ff, 4'h2);
        run(32'hf0710200, 1'b1, 4'he, 32'h0, 32'h0, 32'hffff_ffff);
        expect_wr(32'h0, 1'b1, 4'h5);
        run(32'hf0410200, 1'b1, 4'hf, 32'h1200_0000, 32'h0, 32'h34);
        expect_wr(32'h1200_0034, 1'b0, 4'h0);
        run(32'hf4513a5c, 1'b1, 4'he, 32'h1, 32'h0, 32'h2);
        expect_wr(32'h3, 1'b1, 4'h1);
        check(imm_field_out, 12'hb5c);
        check(wr_addr_ff, 4'ha);
    endtask
    task automatic s_shift();
        logic [4:0] am;
        logic [1:0] t;
        logic [32:0] e;
        logic [31:0] r;
        for (int k = 0; k < 24; k++) begin
            am = (k % 3 == 0) ? 5'h0 : (k % 3 == 1) ? 5'h1 : 5'h1f;
            t = 2'(k / 3);
            e = ref_sh(32'h8000_0081, t, am, 1'b1);
            r = 32'h100 | ((k >= 12) ? ~e[31:0] : e[31:0]);
            run(((k >= 12) ? `LORP_W_ORC_REG : `LORP_W_OR_REG) | 32'h0011_0203
                | {17'h0, am[4:2], 4'h0, am[1:0], t, 4'h0}, 1'b1, 4'he, 32'h100, 32'h8000_0081, 32'h0);
            expect_wr(r, 1'b1, {r[31], r == 32'h0, e[32], 1'b1});
        end
    endtask
    task automatic s_narrow();
        for (int ib = 0; ib < 2; ib++) begin
            @(posedge core_clk);
            in_conditional_block <= ib[0];
            run(32'h431a, 1'b0, 4'he, 32'h0f00_0000, 32'hf0, 32'h0);
            expect_wr(32'h0f00_00f0, !ib[0], 4'h3);
            check(wr_addr_ff, 4'h2);
        end
    endtask
    task automatic s_pack();
        logic [4:0] am;
        logic hsel;
        logic [32:0] e;
        for (int k = 0; k < 3; k++) begin
            hsel = k != 0;
            am = (k == 0) ? 5'h4 : (k == 1) ? 5'h0 : 5'h8;
            e = ref_sh(32'h8765_4321, {hsel, 1'b0}, am, 1'b0);
            run(`LORP_W_PKH | 32'h0001_0203 | {17'h0, am[4:2], 4'h0, am[1:0], hsel, 5'h0}, 1'b1, 4'he,
                32'h1234_5678, 32'h8765_4321, 32'h0);
            expect_wr(hsel ? {16'h1234, e[15:0]} : {e[31:16], 16'h5678}, 1'b0, 4'h0);
        end
    endtask
    task automatic s_reject();
        logic [31:0] rw [12] = '{32'hea41_0203, 32'hea6f_0203, 32'hea4f_0203, 32'hf04f_0200, 32'hea41_0203,
            32'hf061_0200, 32'hea41_0d03, 32'hea61_020f, 32'head1_0203, 32'heac1_0213, 32'heac1_0203,
            32'heacd_0203};
        logic [3:0] ev [12] = '{4'h6, 4'he, 4'he, 4'he, 4'ha, 4'ha, 4'he, 4'he, 4'he, 4'he, 4'hc, 4'he};
        logic [2:0] ex [12] = '{3'h0, 3'h1, 3'h1, 3'h1, 3'h4, 3'h4, 3'h2, 3'h2, 3'h4, 3'h4, 3'h4, 3'h2};
        for (int i = 0; i < 12; i++) begin
            run(rw[i], 1'b1, ev[i], 32'h5, 32'h6, 32'h7);
            check({wr_en_ff, flags_en_ff}, 2'h0);
            check({undefined_ff, unpredictable_ff, redirect_ff}, ex[i]);
            if (ex[i] == 3'h1) check(op_ff, rw[i][21] ? LORP_OP_NOT : LORP_OP_MOVE);
        end
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        s_imm();
        s_shift();
        s_narrow();
        s_pack();
        s_reject();
        print_verdict();
    end
    // about 110 cycles of traffic expected; far longer means a hang
    initial begin
        repeat (2000) @(posedge core_clk);
        num_errors++;
        print_verdict();
    end
endmodule
